// File: rtl/asdc_top.sv
// audio serial dma controller: register bank, ac-link record receiver,
// record fifo and record dma master
// assumes an ahb-lite style slave port, a granted ahb master port and a
// codec that drives the link bit clock
`timescale 1ns/1ps
module asdc_top (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // register slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // dma master port
  input wire logic m_hgrant,
  input wire logic m_hready,
  output logic m_hbusreq,
  output logic m_hlock,
  output logic [1:0] m_htrans,
  output logic [31:0] m_haddr,
  output logic [2:0] m_hburst,
  output logic [2:0] m_hsize,
  output logic m_hwrite,
  output logic [31:0] m_hwdata,
  // ac-link pins
  input wire logic ac_bclk,
  input wire logic ac_sdi,
  output logic ac_sync,
  output logic ac_sdo,
  // playback mover beside this block
  input wire logic play_beat_valid,
  input wire logic [31:0] play_beat_addr,
  input wire logic play_fifo_empty,
  // path controls and interrupt
  output asdc_pkg::asdc_path_t path_ctl,
  output logic dma_irq_n
);
  import asdc_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_REQ, D_BURST, D_LAST} asdc_dma_t;

  typedef struct packed {
    logic [31:0] con;
    logic [31:0] rst_reg;
    logic [31:0] rbase;
    logic [31:0] rlen;
    logic [31:0] rcur;
    logic [31:0] pbase;
    logic [31:0] plen;
    logic [31:0] pcur;
    logic [31:0] i2s_ctl;
    logic [31:0] ac_ctl;
    logic [31:0] os0;
    logic [31:0] os1;
    logic [31:0] os2;
    logic [31:0] is0;
    logic [31:0] is1;
    logic [31:0] is2;
    logic [1:0] rflags;
    logic [1:0] pflags;
    logic [31:0] rd;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic bclk_d;
    logic [7:0] bit_cnt;
    logic sync_o;
    logic [19:0] sh;
    logic [15:0] tag;
    logic [15:0] left;
    logic half;
    logic [15:0] hold;
    logic [1:0] bcnt;
    asdc_sample_t [1:0] bq;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] cnt;
    asdc_dma_t dst;
    logic [2:0] beat;
    asdc_path_t pc;
  } asdc_st_t;

  localparam asdc_st_t ST_INIT = '{os1: OUT1_RESET, dst: D_IDLE, default: '0};

  // {end hit, middle hit} for the word written at addr
  function automatic logic [1:0] dma_hits(input logic [31:0] addr, input logic [31:0] base,
                                          input logic [31:0] len);
    logic [31:0] fin;
    logic [31:0] mid;
    fin = base + len;
    mid = (((fin - base) - 32'h1) >> 1) + base;
    dma_hits = {(addr + ADDR_STEP) == fin, (addr <= mid) && (mid < addr + ADDR_STEP)};
  endfunction

  // address after the word written at addr, wrapping at the end
  function automatic logic [31:0] dma_next(input logic [31:0] addr, input logic [31:0] base,
                                           input logic [31:0] len);
    dma_next = ((addr + ADDR_STEP) == (base + len)) ? base : addr + ADDR_STEP;
  endfunction

  asdc_st_t s;
  asdc_st_t next_s;
  logic bclk_s;
  logic sdi_s;
  logic mem_we;
  logic mem_re;
  asdc_sample_t mem_rdata;
  logic ac_link_on;
  logic rec_on;
  logic [3:0] thr;

  asdc_pin_sync u_bclk_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .pin(ac_bclk),
    .level(bclk_s)
  );

  asdc_pin_sync u_sdi_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .pin(ac_sdi),
    .level(sdi_s)
  );

  // record fifo storage
  asdc_word_mem u_rec_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .we(mem_we),
    .waddr(s.wp),
    .wdata(s.bq[0]),
    .re(mem_re),
    .raddr(s.rp),
    .rdata(mem_rdata)
  );

  // ac-link runs only when the pins are routed to it, it is enabled and out of reset
  assign ac_link_on = s.con[CON_PIN_SEL] & s.con[CON_EN_AC] & ~s.rst_reg[RST_AC_SUB];
  assign rec_on = ac_link_on & s.rst_reg[RST_AC_REC];
  assign thr = s.con[CON_FIFO_LEVEL] ? TH_FOUR : TH_EIGHT;
  assign mem_we = (s.bcnt != 2'h0) && (s.cnt < FIFO_DEPTH);
  assign mem_re = (s.dst == D_BURST) && m_hready && (s.cnt != 4'h0);

  always_comb begin
    logic [19:0] shn;
    logic [1:0] hits;
    logic push;
    asdc_sample_t pword;
    asdc_st_t keep;
    shn = {s.sh[18:0], sdi_s};
    hits = 2'h0;
    push = 1'b0;
    pword = '0;
    keep = '0;
    next_s = s;

    // register writes land in the data phase
    if (s.wr_pend) begin
      case (s.wr_addr)
        REG_CONTROL: begin
          next_s.con = (hwdata & CON_RW_MASK) | (s.con & ~CON_RW_MASK & ~(hwdata & CON_W1C_MASK));
        end
        REG_RESET: next_s.rst_reg = hwdata & RST_RW_MASK;
        REG_REC_BASE: next_s.rbase = hwdata;
        REG_REC_LEN: next_s.rlen = hwdata;
        REG_REC_STAT: next_s.rflags = s.rflags & ~hwdata[1:0];
        REG_PLAY_BASE: next_s.pbase = hwdata;
        REG_PLAY_LEN: next_s.plen = hwdata;
        REG_PLAY_STAT: next_s.pflags = s.pflags & ~hwdata[1:0];
        REG_I2S_CTL: next_s.i2s_ctl = hwdata;
        REG_AC_CTL: next_s.ac_ctl = (hwdata & AC_RW_MASK) | (s.ac_ctl & ~AC_RW_MASK);
        REG_OUT_SLOT0: next_s.os0 = hwdata;
        REG_OUT_SLOT1: next_s.os1 = hwdata;
        REG_OUT_SLOT2: next_s.os2 = hwdata;
        default: next_s.wr_pend = 1'b0;
      endcase
    end

    // address phase: capture writes, answer reads
    next_s.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_s.wr_pend = hwrite;
      next_s.wr_addr = haddr;
      if (!hwrite) begin
        case (haddr)
          REG_CONTROL: next_s.rd = s.con;
          REG_RESET: next_s.rd = s.rst_reg;
          REG_REC_BASE: next_s.rd = s.rbase;
          REG_REC_LEN: next_s.rd = s.rlen;
          REG_REC_CUR: next_s.rd = s.rcur;
          REG_REC_STAT: next_s.rd = {29'h0, s.cnt == FIFO_DEPTH, s.rflags};
          REG_PLAY_BASE: next_s.rd = s.pbase;
          REG_PLAY_LEN: next_s.rd = s.plen;
          REG_PLAY_CUR: next_s.rd = s.pcur;
          REG_PLAY_STAT: next_s.rd = {29'h0, play_fifo_empty, s.pflags};
          REG_I2S_CTL: next_s.rd = s.i2s_ctl;
          REG_AC_CTL: next_s.rd = s.ac_ctl;
          REG_OUT_SLOT0: next_s.rd = s.os0;
          REG_OUT_SLOT1: next_s.rd = s.os1;
          REG_OUT_SLOT2: next_s.rd = s.os2;
          REG_IN_SLOT0: next_s.rd = s.is0;
          REG_IN_SLOT1: next_s.rd = s.is1;
          REG_IN_SLOT2: begin
            next_s.rd = s.is2;
            next_s.ac_ctl[AC_RD_DONE] = 1'b0;
          end
          default: next_s.rd = 32'h0;
        endcase
      end
    end

    // link frame timing and deserialising
    next_s.bclk_d = bclk_s;
    if (!ac_link_on) begin
      next_s.bit_cnt = FRAME_LAST;
      next_s.sync_o = 1'b0;
      next_s.half = 1'b0;
    end else if (bclk_s && !s.bclk_d) begin
      next_s.bit_cnt = s.bit_cnt + 8'h1;
      next_s.sync_o = (s.bit_cnt + 8'h1) < SYNC_BITS;
    end else if (!bclk_s && s.bclk_d) begin
      next_s.sh = shn;
      case (s.bit_cnt)
        TAG_END: begin
          next_s.tag = shn[15:0];
          next_s.is0 = {16'h0, shn[15:0]};
        end
        SLOT1_END: begin
          // index echo and sample requests are stored as received
          if (s.tag[TAG_FRAME] && s.tag[TAG_SLOT1]) begin
            next_s.is1 = {12'h0, shn};
          end
        end
        SLOT2_END: begin
          if (s.tag[TAG_FRAME] && s.tag[TAG_SLOT2]) begin
            next_s.is2 = {12'h0, shn[19:4], 4'h0};
            next_s.ac_ctl[AC_RD_DONE] = 1'b1;
          end
        end
        SLOT3_END: next_s.left = shn[19:4];
        SLOT4_END: begin
          if (rec_on && s.tag[TAG_FRAME]) begin
            case ({s.rst_reg[RST_REC_HI], s.rst_reg[RST_REC_LO]})
              2'b11: begin
                if (s.tag[TAG_SLOT3] && s.tag[TAG_SLOT4]) begin
                  push = 1'b1;
                  pword = '{right: shn[19:4], left: s.left};
                end
              end
              2'b01: begin
                if (s.tag[TAG_SLOT3]) begin
                  next_s.half = ~s.half;
                  next_s.hold = s.left;
                  push = s.half;
                  pword = '{right: s.left, left: s.hold};
                end
              end
              2'b10: begin
                if (s.tag[TAG_SLOT4]) begin
                  next_s.half = ~s.half;
                  next_s.hold = shn[19:4];
                  push = s.half;
                  pword = '{right: shn[19:4], left: s.hold};
                end
              end
              default: push = 1'b0;
            endcase
          end
        end
        default: next_s.sh = shn;
      endcase
    end

    // two-entry buffer drains into the fifo; a word meeting a full buffer is dropped
    if (mem_we) begin
      next_s.bq[0] = s.bq[1];
      next_s.bcnt = s.bcnt - 2'h1;
      next_s.wp = s.wp + 3'h1;
    end
    if (push && (next_s.bcnt != 2'h2)) begin
      next_s.bq[next_s.bcnt[0]] = pword;
      next_s.bcnt = next_s.bcnt + 2'h1;
    end
    case ({mem_we, mem_re})
      2'b10: next_s.cnt = s.cnt + 4'h1;
      2'b01: next_s.cnt = s.cnt - 4'h1;
      default: next_s.cnt = s.cnt;
    endcase

    // record dma master
    case (s.dst)
      D_IDLE: begin
        if (rec_on && (s.cnt >= thr)) begin
          next_s.dst = D_REQ;
        end
      end
      D_REQ: begin
        if (m_hgrant && m_hready) begin
          next_s.dst = D_BURST;
          next_s.beat = 3'h0;
        end
      end
      D_BURST: begin
        if (mem_re) begin
          hits = dma_hits(s.rcur, s.rbase, s.rlen);
          next_s.rcur = dma_next(s.rcur, s.rbase, s.rlen);
          next_s.rp = s.rp + 3'h1;
          next_s.beat = s.beat + 3'h1;
          if (s.beat == BURST_LAST) begin
            next_s.dst = D_LAST;
          end
        end
      end
      D_LAST: begin
        if (m_hready) begin
          next_s.dst = D_IDLE;
        end
      end
      default: next_s.dst = D_IDLE;
    endcase
    // hardware sets win over software clears
    next_s.rflags = next_s.rflags | hits;
    if (hits != 2'h0) begin
      next_s.con[CON_REC_IRQ] = 1'b1;
    end
    if (!rec_on && (s.dst == D_IDLE)) begin
      next_s.rcur = s.rbase;
    end

    // playback beats reported by the neighbouring mover
    if (play_beat_valid) begin
      hits = dma_hits(play_beat_addr, s.pbase, s.plen);
      next_s.pcur = dma_next(play_beat_addr, s.pbase, s.plen);
      next_s.pflags = next_s.pflags | hits;
      if (hits != 2'h0) begin
        next_s.con[CON_TX_IRQ] = 1'b1;
      end
    end

    // decoded path controls for the neighbouring link logic
    next_s.pc.i2s_run = ~s.con[CON_PIN_SEL] & s.con[CON_EN_I2S] & ~s.rst_reg[RST_I2S_SUB];
    next_s.pc.i2s_record = next_s.pc.i2s_run & s.rst_reg[RST_I2S_REC];
    next_s.pc.i2s_play = next_s.pc.i2s_run & s.rst_reg[RST_I2S_PLAY];
    next_s.pc.ac_run = ac_link_on;
    next_s.pc.aclink_record_enable = rec_on;
    next_s.pc.aclink_playback_enable = ac_link_on & s.rst_reg[RST_AC_PLAYBACK];

    // whole-block reset keeps only its own register, the bus phase and the bit clock edge history
    if (s.rst_reg[RST_WHOLE]) begin
      keep = next_s;
      next_s = ST_INIT;
      next_s.rst_reg = keep.rst_reg;
      next_s.wr_pend = keep.wr_pend;
      next_s.wr_addr = keep.wr_addr;
      next_s.rd = keep.rd;
      next_s.bclk_d = keep.bclk_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= ST_INIT;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // slave answers
  assign hrdata = s.rd;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  // master drive
  assign m_hbusreq = (s.dst == D_REQ) || (s.dst == D_BURST);
  assign m_hlock = s.dst != D_IDLE;
  assign m_htrans = mem_re ? ((s.beat == 3'h0) ? HTRANS_NONSEQ : HTRANS_SEQ) :
                    (((s.dst == D_BURST) && (s.beat != 3'h0)) ? HTRANS_BUSY : HTRANS_IDLE);
  assign m_haddr = s.rcur;
  assign m_hburst = HBURST_INCR8;
  assign m_hsize = HSIZE_WORD;
  assign m_hwrite = 1'b1;
  assign m_hwdata = mem_rdata;

  // link and interrupt outputs
  assign ac_sync = s.sync_o;
  assign ac_sdo = 1'b0;
  assign path_ctl = s.pc;
  assign dma_irq_n = ~(s.con[CON_REC_IRQ] | s.con[CON_TX_IRQ]);
endmodule

// File: rtl/asdc_pkg.sv
// constants and carrier types for the audio serial dma controller
// assumes a single 100 mhz system clock and word-aligned bus accesses
package asdc_pkg;
  // register byte addresses
  localparam logic [31:0] REG_CONTROL = 32'hfff09000;
  localparam logic [31:0] REG_RESET = 32'hfff09004;
  localparam logic [31:0] REG_REC_BASE = 32'hfff09008;
  localparam logic [31:0] REG_REC_LEN = 32'hfff0900c;
  localparam logic [31:0] REG_REC_CUR = 32'hfff09010;
  localparam logic [31:0] REG_REC_STAT = 32'hfff09014;
  localparam logic [31:0] REG_PLAY_BASE = 32'hfff09018;
  localparam logic [31:0] REG_PLAY_LEN = 32'hfff0901c;
  localparam logic [31:0] REG_PLAY_CUR = 32'hfff09020;
  localparam logic [31:0] REG_PLAY_STAT = 32'hfff09024;
  localparam logic [31:0] REG_I2S_CTL = 32'hfff09028;
  localparam logic [31:0] REG_AC_CTL = 32'hfff0902c;
  localparam logic [31:0] REG_OUT_SLOT0 = 32'hfff09030;
  localparam logic [31:0] REG_OUT_SLOT1 = 32'hfff09034;
  localparam logic [31:0] REG_OUT_SLOT2 = 32'hfff09038;
  localparam logic [31:0] REG_IN_SLOT0 = 32'hfff0903c;
  localparam logic [31:0] REG_IN_SLOT1 = 32'hfff09040;
  localparam logic [31:0] REG_IN_SLOT2 = 32'hfff09044;
  // control register fields
  localparam int CON_REC_IRQ = 12;
  localparam int CON_TX_IRQ = 11;
  localparam int CON_PIN_SEL = 8;
  localparam int CON_FIFO_LEVEL = 7;
  localparam int CON_EN_AC = 2;
  localparam int CON_EN_I2S = 1;
  localparam logic [31:0] CON_RW_MASK = 32'h00000186;
  localparam logic [31:0] CON_W1C_MASK = 32'h00001800;
  // reset register fields
  localparam int RST_WHOLE = 16;
  localparam int RST_REC_HI = 15;
  localparam int RST_REC_LO = 14;
  localparam int RST_AC_REC = 8;
  localparam int RST_AC_PLAYBACK = 7;
  localparam int RST_I2S_REC = 6;
  localparam int RST_I2S_PLAY = 5;
  localparam int RST_AC_SUB = 1;
  localparam int RST_I2S_SUB = 0;
  localparam logic [31:0] RST_RW_MASK = 32'h0001f1e3;
  // status and ac-link control fields
  localparam int STAT_FIFO = 2;
  localparam int AC_RD_DONE = 4;
  localparam logic [31:0] AC_RW_MASK = 32'h00000026;
  // tag slot valid bits
  localparam int TAG_FRAME = 15;
  localparam int TAG_SLOT1 = 3;
  localparam int TAG_SLOT2 = 4;
  localparam int TAG_SLOT3 = 5;
  localparam int TAG_SLOT4 = 6;
  // reset values
  localparam logic [31:0] OUT1_RESET = 32'h00000080;
  // frame timing in link bit clocks
  localparam logic [7:0] SYNC_BITS = 8'h10;
  localparam logic [7:0] TAG_END = 8'h0f;
  localparam logic [7:0] SLOT_BITS = 8'h14;
  localparam logic [7:0] SLOT1_END = TAG_END + SLOT_BITS;
  localparam logic [7:0] SLOT2_END = SLOT1_END + SLOT_BITS;
  localparam logic [7:0] SLOT3_END = SLOT2_END + SLOT_BITS;
  localparam logic [7:0] SLOT4_END = SLOT3_END + SLOT_BITS;
  // count held while the link is off, so the first rise starts a frame at 0
  localparam logic [7:0] FRAME_LAST = 8'hff;
  // fifo and burst
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] TH_EIGHT = 4'h8;
  localparam logic [3:0] TH_FOUR = 4'h4;
  localparam logic [2:0] BURST_LAST = 3'h7;
  localparam logic [31:0] ADDR_STEP = 32'h00000004;
  // published bus codes
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_BUSY = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HBURST_INCR8 = 3'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic [15:0] right;
    logic [15:0] left;
  } asdc_sample_t;

  typedef struct packed {
    logic i2s_run;
    logic i2s_record;
    logic i2s_play;
    logic ac_run;
    logic aclink_record_enable;
    logic aclink_playback_enable;
  } asdc_path_t;
endpackage

// File: rtl/asdc_pin_sync.sv
// three-stage synchroniser with agreement filter for one link pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module asdc_pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } asdc_sync_st_t;

  asdc_sync_st_t s;
  asdc_sync_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // a change counts once the last two stages agree
    if (s.s2 == s.s3) begin
      next_s.lvl = s.s3;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign level = s.lvl;
endmodule

// File: rtl/asdc_word_mem.sv
// eight-word sample memory with registered read data
// assumes the caller never reads and writes the same word in one cycle
`timescale 1ns/1ps
module asdc_word_mem (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire asdc_pkg::asdc_sample_t wdata,
  // read port
  input wire logic re,
  input wire logic [2:0] raddr,
  output asdc_pkg::asdc_sample_t rdata
);
  import asdc_pkg::*;

  typedef struct packed {
    asdc_sample_t [7:0] mem;
    asdc_sample_t rd;
  } asdc_mem_st_t;

  asdc_mem_st_t s;
  asdc_mem_st_t next_s;

  always_comb begin
    next_s = s;
    if (we) begin
      next_s.mem[waddr] = wdata;
    end
    if (re) begin
      next_s.rd = s.mem[raddr];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata = s.rd;
endmodule

// File: verification/asdc_chk.sv
// checker for asdc_top: dma burst shape, interrupt causes, frame sync width
// assumes one sys_clk domain with rst async active high
`timescale 1ns/1ps
module asdc_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // dma port
  input wire logic m_hready,
  input wire logic m_hbusreq,
  input wire logic m_hlock,
  input wire logic [1:0] m_htrans,
  input wire logic [31:0] m_haddr,
  input wire logic [2:0] m_hburst,
  input wire logic [2:0] m_hsize,
  input wire logic m_hwrite,
  // link and irq
  input wire logic ac_bclk,
  input wire logic ac_sync,
  input wire logic play_beat_valid,
  input wire logic dma_irq_n
);
  import asdc_pkg::*;
  logic [3:0] beats;
  logic [2:0] since_act;
  logic [2:0] since_wr;
  logic [4:0] rises;
  logic [31:0] last_addr;
  // beats in burst, cycles since dma activity or bus write, bit clocks under sync
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      beats <= 4'h0;
      since_act <= 3'h7;
      since_wr <= 3'h7;
      rises <= 5'h0;
      last_addr <= 32'h0;
    end else begin
      if (m_htrans[1] && m_hready) begin
        beats <= m_htrans[0] ? beats + 4'h1 : 4'h1;
        last_addr <= m_haddr;
      end
      since_act <= (m_hlock || play_beat_valid) ? 3'h0 : since_act + {2'h0, since_act != 3'h7};
      since_wr <= (hsel && htrans[1] && hwrite && hready) ? 3'h0 :
        since_wr + {2'h0, since_wr != 3'h7};
      rises <= !ac_sync ? 5'h0 : rises + {4'h0, $rose(ac_bclk)};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_issue;
    m_htrans[1] && m_hready;
  endsequence
  sequence s_next_seq;
    s_issue ##0 m_htrans[0];
  endsequence
  a_burst_shape: assert property (m_htrans[1] |-> m_hlock && m_hwrite &&
    m_hburst == HBURST_INCR8 && m_hsize == HSIZE_WORD) else $error("burst attributes wrong");
  a_addr_step: assert property (s_next_seq |-> m_haddr == last_addr + ADDR_STEP)
    else $error("beat address did not step by one word");
  a_stall_hold: assert property (m_htrans == HTRANS_BUSY |=> $stable(m_haddr))
    else $error("address moved while no beat issued");
  a_burst_start: assert property (m_htrans == HTRANS_NONSEQ |-> beats inside {4'h0, 4'h8})
    else $error("burst started before eight beats");
  a_burst_body: assert property (m_htrans == HTRANS_SEQ |-> beats inside {[4'h1:4'h7]})
    else $error("sequential beat outside burst");
  a_req_locked: assert property (m_hbusreq |-> m_hlock)
    else $error("bus request without lock");
  a_irq_cause: assert property ($fell(dma_irq_n) |-> since_act < 3'h4)
    else $error("interrupt without dma beat");
  a_irq_clear: assert property ($rose(dma_irq_n) |-> since_wr < 3'h4)
    else $error("interrupt released without write");
  a_tag_length: assert property ($fell(ac_sync) |-> rises == 5'h10)
    else $error("frame sync not sixteen bit clocks");
endmodule

// File: verification/asdc_codec_model.sv
// behavioural codec: free-running link bit clock and input frames whose slot 3 and 4 samples count up per frame
// assumes the controller frames with ac_sync; bit k is driven after rise k
`timescale 1ns/1ps
module asdc_codec_model (
  // link pins
  output logic ac_bclk,
  output logic ac_sdi,
  input wire logic ac_sync
);
  logic [7:0] cnt = 8'h80;
  logic [15:0] fnum = 16'h0;
  logic [95:0] frame;
  logic sync_d = 1'b0;
  initial begin
    ac_bclk = 1'b0;
    forever #62.5 ac_bclk = ~ac_bclk;
  end
  task drive_bit;
    frame = {16'h8078,
      20'h26000,
      20'hbeef0,
      16'ha000 + fnum, 4'h0, 16'h5000 + fnum, 4'h0};
    // unused slots toggle every bit so stale data is never seen
    ac_sdi = (cnt < 8'h60) ? frame[8'h5f - cnt] : cnt[0];
  endtask
  // one process owns ac_sdi: a sync rise restarts the frame, a bit clock rise steps it
  always @(posedge ac_bclk or posedge ac_sync) begin
    if (ac_sync && !sync_d) begin
      cnt = 8'h0;
      fnum = fnum + 16'h1;
    end else begin
      cnt = cnt + 8'h1;
    end
    sync_d = ac_sync;
    drive_bit();
  end
endmodule

// File: verification/tb_asdc_top.sv
// bench for asdc_top: registers, play flags, ac-link record dma, link reset
// assumes asdc_codec_model on the link and a memory that stalls while locked
`timescale 1ns/1ps
module tb_asdc_top;
  import asdc_pkg::*;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic m_hgrant = 1'b0;
  logic m_hready = 1'b1;
  logic play_beat_valid = 1'b0;
  logic play_fifo_empty = 1'b1;
  logic pend = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] play_beat_addr = 32'h0;
  logic [31:0] hrdata, m_haddr, m_hwdata, rd;
  logic [1:0] hresp, m_htrans;
  logic [2:0] m_hburst, m_hsize;
  logic hreadyout, m_hbusreq, m_hlock, m_hwrite, ac_bclk, ac_sdi, ac_sync, ac_sdo, dma_irq_n;
  logic [15:0] last_left;
  asdc_path_t path_ctl;
  int mismatches = 0;
  int cmp_count = 0;
  int nbeat = 0;
  asdc_top dut_u (.sys_clk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready(1'b1), .hrdata, .hreadyout, .hresp, .m_hgrant, .m_hready, .m_hbusreq, .m_hlock,
    .m_htrans, .m_haddr, .m_hburst, .m_hsize, .m_hwrite, .m_hwdata, .ac_bclk, .ac_sdi,
    .ac_sync, .ac_sdo, .play_beat_valid, .play_beat_addr, .play_fifo_empty, .path_ctl,
    .dma_irq_n);
  asdc_codec_model codec_u (.ac_bclk, .ac_sdi, .ac_sync);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic pbeat(input logic [31:0] a);
    @(posedge sys_clk);
    play_beat_valid <= 1'b1;
    play_beat_addr <= a;
    @(posedge sys_clk);
    play_beat_valid <= 1'b0;
  endtask
  // memory slave: grant follows request, every other cycle stalls while locked
  always @(posedge sys_clk) begin
    m_hgrant <= m_hbusreq;
    m_hready <= !m_hready || !m_hlock;
    if (m_hready) begin
      if (pend) begin
        chk({16'h0, m_hwdata[31:16] - m_hwdata[15:0]}, 32'hb000);
        if (nbeat > 1) chk({16'h0, m_hwdata[15:0]}, {16'h0, last_left + 16'h1});
        last_left = m_hwdata[15:0];
      end
      pend <= m_htrans[1];
      if (m_htrans[1]) begin
        chk(m_haddr, 32'h1000 + 32'(4 * (nbeat % 8)));
        nbeat++;
      end
    end
  end
  task t_regs;
    for (int i = 0; i < 19; i++) begin
      rdc(REG_CONTROL + 32'(4 * i), ALL, (i == 9) ? 32'h4 : (i == 13) ? 32'h80 : 32'h0);
    end
    bus(1'b1, REG_CONTROL, 32'hfffffffb);
    rdc(REG_CONTROL, ALL, 32'h182);
    bus(1'b1, REG_RESET, 32'hfffeffff);
    rdc(REG_RESET, ALL, 32'hf1e3);
    chk({26'h0, path_ctl}, 32'h0);
    bus(1'b1, REG_RESET, 32'h10000);
    rdc(REG_CONTROL, ALL, 32'h0);
    rdc(REG_RESET, ALL, 32'h10000);
    bus(1'b1, REG_RESET, 32'h0);
    bus(1'b1, REG_REC_BASE, 32'ha5a55a5c);
    bus(1'b1, REG_REC_LEN, 32'h5a5aa5a0);
    bus(1'b1, REG_REC_CUR, 32'h0);
    rdc(REG_REC_BASE, ALL, 32'ha5a55a5c);
    rdc(REG_REC_LEN, ALL, 32'h5a5aa5a0);
    rdc(REG_REC_CUR, ALL, 32'ha5a55a5c);
  endtask
  task t_play;
    bus(1'b1, REG_PLAY_BASE, 32'h2000);
    bus(1'b1, REG_PLAY_LEN, 32'h20);
    play_fifo_empty <= 1'b0;
    pbeat(32'h201c);
    pbeat(32'h200c);
    rdc(REG_PLAY_STAT, ALL, 32'h3);
    rdc(REG_PLAY_CUR, ALL, 32'h2010);
    rdc(REG_CONTROL, ALL, 32'h800);
    chk({31'h0, dma_irq_n}, 32'h0);
    bus(1'b1, REG_CONTROL, 32'h800);
    bus(1'b1, REG_PLAY_STAT, 32'h3);
    rdc(REG_CONTROL, ALL, 32'h0);
    chk({31'h0, dma_irq_n}, 32'h1);
  endtask
  task t_record;
    bus(1'b1, REG_REC_BASE, 32'h1000);
    bus(1'b1, REG_REC_LEN, 32'h20);
    bus(1'b1, REG_RESET, 32'hc100);
    bus(1'b1, REG_CONTROL, 32'h184);
    repeat (3) @(posedge ac_sync);
    rdc(REG_IN_SLOT0, ALL, 32'h8078);
    rdc(REG_IN_SLOT1, ALL, 32'h26000);
    rdc(REG_IN_SLOT2, ALL, 32'hbeef0);
    rdc(REG_AC_CTL, 32'h10, 32'h0);
    chk({26'h0, path_ctl}, 32'h6);
    wait (nbeat >= 8);
    repeat (20) @(posedge sys_clk);
    rdc(REG_REC_STAT, 32'h3, 32'h3);
    rdc(REG_CONTROL, 32'h1000, 32'h1000);
    chk({31'h0, dma_irq_n}, 32'h0);
    bus(1'b1, REG_REC_STAT, 32'h3);
    bus(1'b1, REG_CONTROL, 32'h1184);
    rdc(REG_REC_STAT, 32'h3, 32'h0);
    chk({31'h0, dma_irq_n}, 32'h1);
    wait (nbeat >= 12);
  endtask
  task t_link_reset;
    int hi;
    hi = 0;
    @(negedge ac_sync);
    bus(1'b1, REG_RESET, 32'hc102);
    repeat (3300) begin
      @(posedge sys_clk);
      hi += ac_sync;
    end
    chk(hi, 0);
  endtask
  task conclude;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_play();
    t_record();
    t_link_reset();
    conclude();
  end
  initial begin
    #800000;
    mismatches++;
    conclude();
  end
endmodule
bind asdc_top asdc_chk chk_u (.sys_clk, .rst, .hsel, .htrans, .hwrite, .hready, .m_hready,
  .m_hbusreq, .m_hlock, .m_htrans, .m_haddr, .m_hburst, .m_hsize, .m_hwrite, .ac_bclk,
  .ac_sync, .play_beat_valid, .dma_irq_n);
